/* File: logic/acs_pkg.sv */
// shared constants and types of the conversion sequencer and its master
// Summary of operation
// - stop after acknowledged write restarts, drops result
// - data byte before stop sets new configuration
// - group address 1110111 write is acknowledged too
// - software must let all conversions finish before group
// - group write stop: configuration only if byte
// - group write without byte: start, keep configuration
// - rejection mode from configuration, default simultaneous
// - toggling pin clock detected, oscillator switched off
// - pin address bit reads high under clock
// - no pin clock: internal oscillator runs again
// - source change spoils only the running conversion
// - internal 1x times 133, 160, 147 ms
// - internal 2x times 67, 80, 73.6 ms
// - pin clock: 41036 or 20556 periods
// - filter notch at pin clock over 5120
// - calibration hidden inside every conversion cycle
// - exactly one result per conversion
// - logic held reset while supply low
// - supply good starts 4 ms reset pulse
// - reset clears registers, then converts by itself
// - busy converting: address answered with not-acknowledge
// - default: simultaneous, 1x
package acs_pkg;
    localparam int unsigned CLK_MHZ     = 10;
    // conversion times in microseconds
    localparam int unsigned T60_1X_US   = 133000;
    localparam int unsigned T50_1X_US   = 160000;
    localparam int unsigned TSIM_1X_US  = 147000;
    localparam int unsigned T60_2X_US   = 67000;
    localparam int unsigned T50_2X_US   = 80000;
    localparam int unsigned TSIM_2X_US  = 73600;
    localparam int unsigned POR_US      = 4000;
    localparam int unsigned EXT_TMO_US  = 200;
    localparam int unsigned C60_1X_CYC  = T60_1X_US * CLK_MHZ;
    localparam int unsigned C50_1X_CYC  = T50_1X_US * CLK_MHZ;
    localparam int unsigned CSIM_1X_CYC = TSIM_1X_US * CLK_MHZ;
    localparam int unsigned C60_2X_CYC  = T60_2X_US * CLK_MHZ;
    localparam int unsigned C50_2X_CYC  = T50_2X_US * CLK_MHZ;
    localparam int unsigned CSIM_2X_CYC = TSIM_2X_US * CLK_MHZ;
    localparam int unsigned POR_CYC     = POR_US * CLK_MHZ;
    localparam int unsigned EXT_TMO_CYC = EXT_TMO_US * CLK_MHZ;
    // pin clock periods per conversion, notch divider
    localparam int unsigned EXT_1X_PER  = 41036;
    localparam int unsigned EXT_2X_PER  = 20556;
    localparam int unsigned NOTCH_DIV   = 5120;
    localparam logic [6:0]  GLOBAL_ADDR = 7'h77;
    // configuration byte layout
    localparam int unsigned CFG_SPD_BIT = 0;
    localparam int unsigned CFG_REJ_LSB = 1;
    localparam logic [7:0]  CFG_RESET   = 8'h00;
    // master register map and fields
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_ADDR    = 8'h04;
    localparam logic [7:0]  REG_DATA    = 8'h08;
    localparam logic [7:0]  REG_STAT    = 8'h0C;
    localparam int unsigned CTRL_GO     = 0;
    localparam int unsigned CTRL_SEND   = 1;
    localparam int unsigned STAT_DONE   = 3;
    localparam int unsigned SCL_QTR_CYC = 5;
    typedef enum logic [1:0] {REJ_SIM, REJ_50, REJ_60, REJ_RSV} acs_rej_t;
    typedef enum logic [1:0] {D_IDLE, D_ADDR, D_DATA, D_SKIP} acs_dst_t;
    typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} acs_hst_t;
endpackage

/* File: logic/acs_bus_if.sv */
// two-wire bus between the master and the converter sequencer
`timescale 1ns/1ps
interface acs_bus_if;
    logic h_scl_o;
    logic h_scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;
    // open drain with pull-up: only a driven low counts
    assign scl = ~(h_scl_oe & ~h_scl_o);
    assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
    modport dev  (input scl, input sda, output d_sda_o, output d_sda_oe);
    modport host (input scl, input sda, output h_scl_o, output h_scl_oe,
                  output h_sda_o, output h_sda_oe);
endinterface

/* File: logic/acs_clk_detect.sv */
// detector for a conversion clock on the shared address pin
`timescale 1ns/1ps
module acs_clk_detect #(
    parameter int unsigned TIMEOUT = acs_pkg::EXT_TMO_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      present,
    output logic      rise
);
    logic        pin_q;
    logic        armed;
    logic [15:0] idle;

    // pin is synchronous already; one stage gives the edge; the first
    // sample after reset only loads, so a strapped-high pin is no edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
            armed <= 1'b0;
        end else begin
            pin_q <= pin;
            armed <= 1'b1;
        end
    end
    assign rise = pin & ~pin_q & armed;

    // any edge restarts the silence timer; slow clocks time out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle    <= '0;
            present <= 1'b0;
        end else if (pin != pin_q) begin
            idle    <= '0;
            present <= present | rise;
        end else if (idle == 16'(TIMEOUT - 1)) begin
            present <= 1'b0;
        end else begin
            idle <= idle + 16'h0001;
        end
    end
endmodule

/* File: logic/acs_device.sv */
// converter-side sequencer: bus target, clock source and conversion timer
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module acs_device #(
    parameter int unsigned C60_1X  = acs_pkg::C60_1X_CYC,
    parameter int unsigned C50_1X  = acs_pkg::C50_1X_CYC,
    parameter int unsigned CSIM_1X = acs_pkg::CSIM_1X_CYC,
    parameter int unsigned C60_2X  = acs_pkg::C60_2X_CYC,
    parameter int unsigned C50_2X  = acs_pkg::C50_2X_CYC,
    parameter int unsigned CSIM_2X = acs_pkg::CSIM_2X_CYC,
    parameter int unsigned EXT_1X  = acs_pkg::EXT_1X_PER,
    parameter int unsigned EXT_2X  = acs_pkg::EXT_2X_PER,
    parameter int unsigned POR_LEN = acs_pkg::POR_CYC
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    acs_bus_if.dev          bus,
    input  wire logic [5:0] dev_addr_hi,
    input  wire logic       addr_or_conv_clock_pin,
    output logic            converting,
    output logic            conv_done,
    output logic [7:0]      cfg,
    output logic            ext_clk_mode,
    output logic            osc_enable,
    output logic            por_busy,
    output logic            notch_tick
);
    localparam int CW = 21;

    logic              ext_present;
    logic              ext_rise;
    logic [CW-1:0]     por_cnt;
    logic              por_end;
    logic              scl_q;
    logic              sda_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              bus_start;
    logic              bus_stop;
    acs_pkg::acs_dst_t st;
    logic [3:0]        cnt;
    logic [7:0]        shreg;
    logic [7:0]        pend;
    logic              selected;
    logic              got_data;
    logic [6:0]        own_addr;
    logic              addr_ok;
    logic              start_conv;
    logic [7:0]        next_cfg;
    logic [CW-1:0]     next_len;
    logic [CW-1:0]     remain;
    logic              tick;
    logic [12:0]       notch_cnt;

    acs_clk_detect #(
        .TIMEOUT (acs_pkg::EXT_TMO_CYC)
    ) u_det (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (addr_or_conv_clock_pin),
        .present (ext_present),
        .rise    (ext_rise)
    );

    // clock source flags follow the detector one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_clk_mode <= 1'b0;
            osc_enable   <= 1'b1;
        end else begin
            ext_clk_mode <= ext_present;
            osc_enable   <= ~ext_present;
        end
    end

    // presetn stands for the supply monitor; release starts the pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt  <= '0;
            por_busy <= 1'b1;
        end else if (por_busy) begin
            if (por_end) begin
                por_busy <= 1'b0;
            end
            por_cnt <= por_cnt + CW'(1);
        end
    end
    assign por_end = por_busy && (por_cnt == CW'(POR_LEN - 1));

    // bus levels are synchronous; one stage finds edges and conditions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= bus.scl;
            sda_q <= bus.sda;
        end
    end
    assign scl_rise  = bus.scl & ~scl_q;
    assign scl_fall  = ~bus.scl & scl_q;
    assign bus_start = bus.scl & scl_q & sda_q & ~bus.sda;
    assign bus_stop  = bus.scl & scl_q & ~sda_q & bus.sda;

    // a running pin clock stands in for a high address bit
    assign own_addr = {dev_addr_hi,
                       ext_clk_mode | addr_or_conv_clock_pin};
    // only writes are taken, and only while asleep
    assign addr_ok = !converting && !shreg[0] &&
                     (shreg[7:1] == own_addr ||
                      shreg[7:1] == acs_pkg::GLOBAL_ADDR);

    // bit engine: shift on scl rise, acknowledge from the 8th fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st           <= acs_pkg::D_IDLE;
            cnt          <= 4'h0;
            shreg        <= 8'h00;
            pend         <= acs_pkg::CFG_RESET;
            selected     <= 1'b0;
            got_data     <= 1'b0;
            bus.d_sda_oe <= 1'b0;
        end else if (por_busy) begin
            st           <= acs_pkg::D_IDLE;
            bus.d_sda_oe <= 1'b0;
        end else if (bus_start) begin
            // a repeated start keeps the selection of the session
            st           <= acs_pkg::D_ADDR;
            cnt          <= 4'h0;
            bus.d_sda_oe <= 1'b0;
        end else if (bus_stop) begin
            st           <= acs_pkg::D_IDLE;
            selected     <= 1'b0;
            got_data     <= 1'b0;
            bus.d_sda_oe <= 1'b0;
        end else if (st != acs_pkg::D_IDLE) begin
            if (scl_rise && cnt != 4'h9) begin
                if (cnt < 4'h8) begin
                    shreg <= {shreg[6:0], bus.sda};
                end
                cnt <= cnt + 4'h1;
            end
            if (scl_fall && cnt == 4'h8) begin
                if (st == acs_pkg::D_ADDR) begin
                    bus.d_sda_oe <= addr_ok;
                    selected     <= selected | addr_ok;
                end else if (st == acs_pkg::D_DATA) begin
                    bus.d_sda_oe <= 1'b1;
                    pend         <= shreg;
                    got_data     <= 1'b1;
                end
            end
            if (scl_fall && cnt == 4'h9) begin
                bus.d_sda_oe <= 1'b0;
                cnt          <= 4'h0;
                if (st == acs_pkg::D_ADDR) begin
                    st <= bus.d_sda_oe ? acs_pkg::D_DATA : acs_pkg::D_SKIP;
                end
            end
        end
    end

    // open drain: the level driven is always low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.d_sda_o <= 1'b0;
        end else begin
            bus.d_sda_o <= 1'b0;
        end
    end

    // configuration only changes at a stop that closes a data byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= acs_pkg::CFG_RESET;
        end else if (bus_stop && selected && got_data) begin
            cfg <= pend;
        end
    end

    // the conversion that a stop starts already uses the new byte
    always_comb begin
        next_cfg = (bus_stop && selected && got_data) ? pend : cfg;
        if (ext_present) begin
            next_len = next_cfg[acs_pkg::CFG_SPD_BIT] ?
                       CW'(EXT_2X) : CW'(EXT_1X);
        end else if (next_cfg[acs_pkg::CFG_SPD_BIT]) begin
            case (acs_pkg::acs_rej_t'(next_cfg[acs_pkg::CFG_REJ_LSB +: 2]))
                acs_pkg::REJ_60: next_len = CW'(C60_2X);
                acs_pkg::REJ_50: next_len = CW'(C50_2X);
                default:         next_len = CW'(CSIM_2X);
            endcase
        end else begin
            case (acs_pkg::acs_rej_t'(next_cfg[acs_pkg::CFG_REJ_LSB +: 2]))
                acs_pkg::REJ_60: next_len = CW'(C60_1X);
                acs_pkg::REJ_50: next_len = CW'(C50_1X);
                default:         next_len = CW'(CSIM_1X);
            endcase
        end
    end

    // stop of a session, or the end of the reset pulse, starts a run
    assign start_conv = por_end | (bus_stop & selected);
    // with a pin clock only its rising edges advance the timer
    assign tick = ext_present ? ext_rise : 1'b1;

    // conversion timer; calibration sits inside each timed run, so
    // the bus sees the same convert/sleep cycle either way
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converting <= 1'b0;
            remain     <= '0;
            conv_done  <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (start_conv) begin
                converting <= 1'b1;
                remain     <= next_len;
            end else if (converting) begin
                if (ext_present != ext_clk_mode) begin
                    remain <= next_len;
                end else if (tick) begin
                    if (remain == CW'(1)) begin
                        converting <= 1'b0;
                        conv_done  <= 1'b1;
                    end
                    remain <= remain - CW'(1);
                end
            end
        end
    end

    // filter frame marker: one pulse every divider pin clock periods
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            notch_cnt  <= 13'h0000;
            notch_tick <= 1'b0;
        end else begin
            notch_tick <= 1'b0;
            if (!converting || !ext_present) begin
                notch_cnt <= 13'h0000;
            end else if (ext_rise) begin
                if (notch_cnt == 13'(acs_pkg::NOTCH_DIV - 1)) begin
                    notch_cnt  <= 13'h0000;
                    notch_tick <= 1'b1;
                end else begin
                    notch_cnt <= notch_cnt + 13'h0001;
                end
            end
        end
    end
endmodule

/* File: logic/acs_host.sv */
// bus master: apb registers drive write sessions to the converters
`timescale 1ns/1ps
module acs_host #(
    parameter int unsigned QTR = acs_pkg::SCL_QTR_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    acs_bus_if.host          bus
);
    acs_pkg::acs_hst_t hs;
    logic [6:0]        tgt;
    logic [7:0]        dbyte;
    logic              send;
    logic              go;
    logic              busy;
    logic              addr_ack;
    logic              data_ack;
    logic              done;
    logic              done_set;
    logic [1:0]        ph;
    logic [7:0]        qcnt;
    logic [3:0]        bitn;
    logic              byten;
    logic [7:0]        shreg;
    logic              mapped;
    logic              wr;

    assign mapped = paddr == acs_pkg::REG_CTRL || paddr == acs_pkg::REG_ADDR
                 || paddr == acs_pkg::REG_DATA || paddr == acs_pkg::REG_STAT;
    assign wr = psel & penable & pwrite & mapped;

    // zero wait states: answer is prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= ~mapped;
                case (paddr)
                    acs_pkg::REG_ADDR: prdata <= {25'h000_0000, tgt};
                    acs_pkg::REG_DATA: prdata <= {24'h00_0000, dbyte};
                    acs_pkg::REG_STAT: prdata <= {28'h000_0000, done,
                                                  data_ack, addr_ack, busy};
                    acs_pkg::REG_CTRL: prdata <= {30'h0000_0000, send, 1'b0};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software settings; a start while busy is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt   <= acs_pkg::GLOBAL_ADDR;
            dbyte <= acs_pkg::CFG_RESET;
            send  <= 1'b0;
            go    <= 1'b0;
        end else begin
            go <= 1'b0;
            if (wr && paddr == acs_pkg::REG_ADDR) tgt <= pwdata[6:0];
            if (wr && paddr == acs_pkg::REG_DATA) dbyte <= pwdata[7:0];
            if (wr && paddr == acs_pkg::REG_CTRL) begin
                send <= pwdata[acs_pkg::CTRL_SEND];
                go   <= pwdata[acs_pkg::CTRL_GO] & ~busy;
            end
        end
    end

    // sticky done; a new completion wins over a clear by write-one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else begin
            done <= done_set | (done & ~(wr && paddr == acs_pkg::REG_STAT
                                && pwdata[acs_pkg::STAT_DONE]));
        end
    end

    // open drain: the driven level is always low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.h_scl_o <= 1'b0;
            bus.h_sda_o <= 1'b0;
        end else begin
            bus.h_scl_o <= 1'b0;
            bus.h_sda_o <= 1'b0;
        end
    end

    // session engine: four quarter phases per bit, scl high in 2 and 3;
    // software must let every converter finish before a group call
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs           <= acs_pkg::H_IDLE;
            ph           <= 2'h0;
            qcnt         <= 8'h00;
            bitn         <= 4'h0;
            byten        <= 1'b0;
            shreg        <= 8'h00;
            busy         <= 1'b0;
            addr_ack     <= 1'b0;
            data_ack     <= 1'b0;
            done_set     <= 1'b0;
            bus.h_scl_oe <= 1'b0;
            bus.h_sda_oe <= 1'b0;
        end else begin
            done_set <= 1'b0;
            if (hs == acs_pkg::H_IDLE) begin
                if (go) begin
                    hs       <= acs_pkg::H_START;
                    busy     <= 1'b1;
                    ph       <= 2'h0;
                    qcnt     <= 8'h00;
                    bitn     <= 4'h0;
                    byten    <= 1'b0;
                    shreg    <= {tgt, 1'b0};
                    addr_ack <= 1'b0;
                    data_ack <= 1'b0;
                end
            end else if (qcnt != 8'(QTR - 1)) begin
                qcnt <= qcnt + 8'h01;
            end else begin
                qcnt <= 8'h00;
                ph   <= ph + 2'h1;
                case (hs)
                    acs_pkg::H_START: begin
                        if (ph == 2'h1) bus.h_sda_oe <= 1'b1;
                        if (ph == 2'h3) begin
                            bus.h_scl_oe <= 1'b1;
                            hs           <= acs_pkg::H_BITS;
                        end
                    end
                    acs_pkg::H_BITS: begin
                        if (ph == 2'h0) begin
                            bus.h_sda_oe <= (bitn != 4'h8) & ~shreg[7];
                        end
                        if (ph == 2'h1) bus.h_scl_oe <= 1'b0;
                        if (ph == 2'h2 && bitn == 4'h8) begin
                            if (byten) data_ack <= ~bus.sda;
                            else       addr_ack <= ~bus.sda;
                        end
                        if (ph == 2'h3) begin
                            bus.h_scl_oe <= 1'b1;
                            if (bitn != 4'h8) begin
                                bitn  <= bitn + 4'h1;
                                shreg <= {shreg[6:0], 1'b0};
                            end else if (!byten && send && addr_ack) begin
                                bitn  <= 4'h0;
                                byten <= 1'b1;
                                shreg <= dbyte;
                            end else begin
                                hs <= acs_pkg::H_STOP;
                            end
                        end
                    end
                    acs_pkg::H_STOP: begin
                        if (ph == 2'h0) bus.h_sda_oe <= 1'b1;
                        if (ph == 2'h1) bus.h_scl_oe <= 1'b0;
                        if (ph == 2'h2) bus.h_sda_oe <= 1'b0;
                        if (ph == 2'h3) begin
                            hs       <= acs_pkg::H_IDLE;
                            busy     <= 1'b0;
                            done_set <= 1'b1;
                        end
                    end
                    default: hs <= acs_pkg::H_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: testbench/acs_checker_properties.sv */
// checker: bus and status relations of the conversion sequencer
`timescale 1ns/1ps
module acs_checker_properties (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       scl,
    input wire logic       d_sda_oe,
    input wire logic       converting,
    input wire logic       conv_done,
    input wire logic       por_busy,
    input wire logic [7:0] cfg
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a finished conversion gives its single result as busy drops
    sequence s_end;
        conv_done && !converting;
    endsequence
    AST_END: assert property ($fell(converting) |-> s_end)
        else $error("end without result");
    AST_ONE: assert property (conv_done |=> !conv_done)
        else $error("result repeated");
    AST_POR: assert property ($fell(por_busy) |-> converting)
        else $error("no conversion after power-on");
    AST_BUSY: assert property (converting |-> !d_sda_oe)
        else $error("ack while converting");
    AST_QUIET: assert property (por_busy |-> !d_sda_oe)
        else $error("bus driven in power-on");
    AST_CFG: assert property ($changed(cfg) |-> $rose(converting))
        else $error("cfg changed outside start");
    AST_ACKON: assert property ($rose(d_sda_oe) |-> !scl && !$past(scl))
        else $error("ack driven while clock high");
    AST_ACKOFF: assert property ($fell(d_sda_oe) |-> !scl && !$past(scl))
        else $error("ack released while clock high");
endmodule

/* File: testbench/tb_adc_conversion_sequencer.sv */
// testbench: apb sessions against a model of cfg and conversion length
`timescale 1ns/1ps
module tb_adc_conversion_sequencer;
    logic        pclk, presetn, psel, penable, pwrite, pin, ext_on, err;
    logic        pready, pslverr, converting, conv_done, ext_mode, osc;
    logic        por_busy, pin_d;
    logic [7:0]  paddr, cfg;
    logic [5:0]  addr_hi;
    logic [31:0] pwdata, prdata, rd;
    int          n_fail, total_checks, ccyc, crise, exp_cfg, d;
    int          seed = 32'h0000_6a10;
    // scaled-down lengths: 1x internal, pin clock rises in 2x, power-on
    localparam int L60 = 300, L50 = 400, LSIM = 350, LPIN = 10, LPOR = 50;
    // model lengths indexed by {speed, rejection}; 2x halves each time
    int          lt[8] = '{LSIM, L50, L60, LSIM,
                           LSIM / 2, L50 / 2, L60 / 2, LSIM / 2};
    acs_bus_if acs_bus_if_inst();
    acs_host acs_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus(acs_bus_if_inst));
    acs_device #(.C60_1X(L60), .C50_1X(L50), .CSIM_1X(LSIM),
        .C60_2X(L60 / 2), .C50_2X(L50 / 2), .CSIM_2X(LSIM / 2),
        .EXT_1X(2 * LPIN), .EXT_2X(LPIN), .POR_LEN(LPOR))
        acs_device_inst(.pclk(pclk), .presetn(presetn),
        .bus(acs_bus_if_inst), .dev_addr_hi(addr_hi),
        .addr_or_conv_clock_pin(pin), .converting(converting),
        .conv_done(conv_done), .cfg(cfg), .ext_clk_mode(ext_mode),
        .osc_enable(osc), .por_busy(por_busy), .notch_tick());
    acs_checker_properties chk_inst(.pclk(pclk), .presetn(presetn),
        .scl(acs_bus_if_inst.scl), .d_sda_oe(acs_bus_if_inst.d_sda_oe),
        .converting(converting), .conv_done(conv_done),
        .por_busy(por_busy), .cfg(cfg));
    initial begin pclk = 0; forever #50 pclk = ~pclk; end
    // pin clock toggles on pclk edges; pin_d mirrors the device's edge
    // stage, so the model counts exactly the rises that it will see
    always @(posedge pclk) {pin, pin_d} <= {ext_on & ~pin, pin};
    always @(posedge pclk) ccyc <= converting ? ccyc + 1 : 0;
    always @(posedge pclk) crise <= converting ? crise + (pin & ~pin_d) : 0;
    task automatic chk(logic [31:0] g, logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] v);
        int k;
        k = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 40);
        if (pready !== 1'b1) n_fail++;
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    // full write session: address, optional byte, stop; then status
    task automatic sess(logic [6:0] a, logic [7:0] v, logic s, logic ack);
        int k;
        k = 0;
        apb(1'b1, 8'h04, 32'(a));
        apb(1'b1, 8'h08, 32'(v));
        apb(1'b1, 8'h00, {30'h0000_0000, s, 1'b1});
        do begin apb(1'b0, 8'h0c, 32'h0000_0000); k++; end
            while (rd[3] !== 1'b1 && k < 600);
        chk(rd[3:1], {1'b1, ack & s, ack});
        apb(1'b1, 8'h0c, 32'h0000_0008);
        if (ack && s) exp_cfg = v;
    endtask
    // wait for the result, then compare length and configuration
    task automatic conv(int n, logic ext);
        int k;
        k = 0;
        while (conv_done !== 1'b1 && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        chk(conv_done, 1'b1);
        chk(ext ? crise : ccyc, n);
        chk(cfg, exp_cfg);
    endtask
    task automatic wrap_up;
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ext_on, presetn} = '0;
        exp_cfg = 0;
        addr_hi = 6'h0a;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        conv(LSIM, 1'b0);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(err, 1'b1);
        // speed and rejection codes 0 to 7, but 2 and 5 go without byte; group and own, byte or none
        for (int i = 0; i < 8; i++) begin
            d = ($random(seed) & 32'h0000_00f8) | i;
            sess(i[1] ? 7'h77 : 7'h14, d[7:0], i % 3 != 2, 1'b1);
            conv(lt[exp_cfg[0] * 4 + exp_cfg[2:1]], 1'b0);
            $display("test %0d done", i);
        end
        sess(7'h14, 8'h02, 1'b1, 1'b1);
        sess(7'h14, 8'h05, 1'b1, 1'b0);
        conv(L50, 1'b0);
        sess(7'h33, 8'h01, 1'b1, 1'b0);
        chk(converting, 1'b0);
        $display("test refusals done");
        ext_on <= 1'b1;
        repeat (40) @(posedge pclk);
        chk({ext_mode, osc}, 2'b10);
        sess(7'h15, 8'h01, 1'b1, 1'b1);
        conv(LPIN, 1'b1);
        ext_on <= 1'b0;
        repeat (2100) @(posedge pclk);
        chk({ext_mode, osc}, 2'b01);
        $display("test pin clock done");
        wrap_up;
    end
    initial begin
        #(100 * 40000);
        n_fail++;
        wrap_up;
    end
endmodule
